/* File: design/scwp_pkg.sv */
package scwp_pkg;
   localparam int FRAME_BITS = 32;
   localparam logic [11:0] HEADER = 12'h001;
   localparam logic [3:0] A_CAL = 4'h0;
   localparam logic [3:0] A_CFG = 4'h1;
   localparam logic [3:0] A_OFS1 = 4'h2;
   localparam logic [3:0] A_FS1 = 4'h3;
   localparam logic [3:0] A_XCFG = 4'h9;
   localparam logic [3:0] A_OFS2 = 4'hA;
   localparam logic [3:0] A_FS2 = 4'hB;
   localparam logic [3:0] A_PHF = 4'hE;
   localparam logic [3:0] A_PHC = 4'hF;
   localparam logic [15:0] RST_CAL = 16'h7FFF;
   localparam logic [15:0] RST_CFG = 16'hB2FF;
   localparam logic [15:0] RST_OFS = 16'h007F;
   localparam logic [15:0] RST_FS = 16'h807F;
   localparam logic [15:0] RST_XCFG = 16'h03FF;
   localparam logic [15:0] RST_PHF = 16'h00FF;
   localparam logic [15:0] RST_PHC = 16'h007F;
   localparam int CAL_BIT = 15;
   localparam int NREG = 9;

   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] data;
   } scwp_word_s;

   typedef struct packed {
      logic [15:0] cfg;
      logic [15:0] ofs1;
      logic [15:0] fs1;
      logic [15:0] xcfg;
      logic [15:0] ofs2;
      logic [15:0] fs2;
      logic [15:0] phf;
      logic [15:0] phc;
   } scwp_regs_s;
endpackage

/* File: design/scwp_serial_config_write_port.sv */
// What this block does
// - Port traffic is taken only in extended control mode.
// - One data bit captured per serial clock rising edge while select low.
// - Receiver works at any slow or stopped serial clock rate.
// - Frames are exactly 32 bits, most significant bit first.
// - First twelve bits are eleven zeros then a one.
// - Four address bits then sixteen data bits follow the header.
// - A new frame starts at the 33rd edge without releasing select.
// - Register contents survive power-down.
// - Address decode covers nine registers; other codes are reserved.
// - Registers are write-only and inert outside extended mode.
// - Writing one to calibration bit 15 starts a calibration.
// - Calibration bit is ORed with the external calibration pin.
// - Power-on reset loads every register with its default.
`timescale 1ns/1ns
module scwp_serial_config_write_port
(
   input  wire logic              sys_clk,
   input  wire logic              nrst,
   input  wire logic              cfg_sclk,
   input  wire logic              cfg_select_n,
   input  wire logic              cfg_serial_in,
   input  wire logic              ext_mode,
   input  wire logic              power_down,
   input  wire logic              cal_pin,
   output logic                   cal_request,
   output scwp_pkg::scwp_regs_s   regs,
   output logic                   regs_active
);

   // Link domain: shift register on the serial clock, reset by select high
   logic [4:0]              bit_cnt_r;
   logic [4:0]              bit_cnt_nxt;
   logic [30:0]             shift_r;
   logic [30:0]             shift_nxt;
   scwp_pkg::scwp_word_s    word_r;
   scwp_pkg::scwp_word_s    word_nxt;
   logic                    tgl_r;
   logic                    tgl_nxt;
   logic [31:0]             frame;
   logic                    ext_l1_r;
   logic                    ext_l2_r;

   assign frame = {shift_r, cfg_serial_in};

   // Mode level crosses into the link domain; first stage read only by second
   always_ff @(posedge cfg_sclk or negedge nrst)
   begin
      if (!nrst)
      begin
         ext_l1_r <= 1'b0;
         ext_l2_r <= 1'b0;
      end
      else
      begin
         ext_l1_r <= ext_mode;
         ext_l2_r <= ext_l1_r;
      end
   end

   always_comb
   begin
      bit_cnt_nxt = bit_cnt_r + 5'h01;
      shift_nxt   = frame[30:0];
      word_nxt    = word_r;
      tgl_nxt     = tgl_r;
      if (bit_cnt_r == 5'h1F && ext_l2_r)
      begin
         if (frame[31:20] == scwp_pkg::HEADER)
         begin
            word_nxt.addr = frame[19:16];
            word_nxt.data = frame[15:0];
            tgl_nxt       = ~tgl_r;
         end
      end
   end

   // Select high clears the count, so a partial frame never completes; no
   // edge is needed between frames, which suits a stopped clock
   always_ff @(posedge cfg_sclk or posedge cfg_select_n)
   begin
      if (cfg_select_n)
      begin
         bit_cnt_r <= 5'h00;
         shift_r   <= 31'h0000_0000;
      end
      else
      begin
         bit_cnt_r <= bit_cnt_nxt;
         shift_r   <= shift_nxt;
      end
   end

   always_ff @(posedge cfg_sclk or negedge nrst)
   begin
      if (!nrst)
      begin
         word_r <= '0;
         tgl_r  <= 1'b0;
      end
      else
      begin
         word_r <= word_nxt;
         tgl_r  <= tgl_nxt;
      end
   end

   // System domain: toggle synchroniser, word held stable for many cycles
   logic                    tgl_s1_r;
   logic                    tgl_s2_r;
   logic                    tgl_s3_r;
   logic                    ext_s1_r;
   logic                    ext_s2_r;
   logic                    cal_s1_r;
   logic                    cal_s2_r;
   logic                    pd_s1_r;
   logic                    pd_s2_r;
   logic                    wr_stb;
   scwp_pkg::scwp_regs_s    regs_r;
   scwp_pkg::scwp_regs_s    regs_nxt;
   logic                    cal_bit_r;
   logic                    cal_bit_nxt;
   logic                    cal_req_r;
   logic                    cal_req_nxt;

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tgl_s1_r <= 1'b0;
         tgl_s2_r <= 1'b0;
         tgl_s3_r <= 1'b0;
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         cal_s1_r <= 1'b0;
         cal_s2_r <= 1'b0;
         pd_s1_r  <= 1'b0;
         pd_s2_r  <= 1'b0;
      end
      else
      begin
         tgl_s1_r <= tgl_r;
         tgl_s2_r <= tgl_s1_r;
         tgl_s3_r <= tgl_s2_r;
         ext_s1_r <= ext_mode;
         ext_s2_r <= ext_s1_r;
         cal_s1_r <= cal_pin;
         cal_s2_r <= cal_s1_r;
         pd_s1_r  <= power_down;
         pd_s2_r  <= pd_s1_r;
      end
   end

   assign wr_stb = tgl_s2_r ^ tgl_s3_r;

   always_comb
   begin
      regs_nxt    = regs_r;
      cal_bit_nxt = 1'b0;
      if (wr_stb && ext_s2_r)
      begin
         case (word_r.addr)
            scwp_pkg::A_CAL:  cal_bit_nxt   = word_r.data[scwp_pkg::CAL_BIT];
            scwp_pkg::A_CFG:  regs_nxt.cfg  = word_r.data;
            scwp_pkg::A_OFS1: regs_nxt.ofs1 = word_r.data;
            scwp_pkg::A_FS1:  regs_nxt.fs1  = word_r.data;
            scwp_pkg::A_XCFG: regs_nxt.xcfg = word_r.data;
            scwp_pkg::A_OFS2: regs_nxt.ofs2 = word_r.data;
            scwp_pkg::A_FS2:  regs_nxt.fs2  = word_r.data;
            scwp_pkg::A_PHF:  regs_nxt.phf  = word_r.data;
            scwp_pkg::A_PHC:  regs_nxt.phc  = word_r.data;
            default:          regs_nxt      = regs_r;
         endcase
      end
      // Calibration pin always acts; the register bit only in extended mode
      cal_req_nxt = cal_s2_r | cal_bit_r;
   end

   // Power-down is deliberately not a term here so contents are kept
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         regs_r.cfg  <= scwp_pkg::RST_CFG;
         regs_r.ofs1 <= scwp_pkg::RST_OFS;
         regs_r.fs1  <= scwp_pkg::RST_FS;
         regs_r.xcfg <= scwp_pkg::RST_XCFG;
         regs_r.ofs2 <= scwp_pkg::RST_OFS;
         regs_r.fs2  <= scwp_pkg::RST_FS;
         regs_r.phf  <= scwp_pkg::RST_PHF;
         regs_r.phc  <= scwp_pkg::RST_PHC;
         cal_bit_r   <= 1'b0;
         cal_req_r   <= 1'b0;
      end
      else
      begin
         regs_r    <= regs_nxt;
         cal_bit_r <= cal_bit_nxt;
         cal_req_r <= cal_req_nxt;
      end
   end

   assign regs        = regs_r;
   assign regs_active = ext_s2_r & ~pd_s2_r;
   assign cal_request = cal_req_r;

endmodule

/* File: testbench/scwp_checker_assertions.sv */
`timescale 1ns/1ns
module scwp_checker
(
   input wire logic            sys_clk,
   input wire logic            nrst,
   input wire logic            cfg_select_n,
   input wire logic            ext_mode,
   input wire logic            power_down,
   input wire logic            cal_pin,
   input wire logic            cal_request,
   input scwp_pkg::scwp_regs_s regs,
   input wire logic            regs_active
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // Cycles since the mode was last on and since select was last low
   logic [4:0] off_r;
   logic [4:0] sel_r;
   always_ff @(posedge sys_clk or negedge nrst)
      if (!nrst)
      begin
         off_r <= 5'h00;
         sel_r <= 5'h1F;
      end
      else
      begin
         off_r <= ext_mode ? 5'h00 : off_r + {4'h0, off_r != 5'h1F};
         sel_r <= !cfg_select_n ? 5'h00 : sel_r + {4'h0, sel_r != 5'h1F};
      end
   property p_moff; (!ext_mode)[*4] |-> !regs_active; endproperty
   a_moff: assert property (p_moff) else $error("active in mode off");
   property p_pdoff; power_down[*4] |-> !regs_active; endproperty
   a_pdoff: assert property (p_pdoff) else $error("active in power-down");
   property p_mon; (ext_mode && !power_down)[*5] |-> regs_active; endproperty
   a_mon: assert property (p_mon) else $error("inactive in mode on");
   property p_idle; off_r > 5'h10 |-> $stable(regs); endproperty
   a_idle: assert property (p_idle) else $error("write in mode off");
   property p_frame; !$stable(regs) |-> sel_r < 5'h0A; endproperty
   a_frame: assert property (p_frame) else $error("write without frame");
   property p_pin; cal_pin[*4] |-> cal_request; endproperty
   a_pin: assert property (p_pin) else $error("pin not passed");
   property p_pulse; (!cal_pin)[*5] ##0 cal_request |=> !cal_request; endproperty
   a_pulse: assert property (p_pulse) else $error("pulse too long");
   property p_quiet; (!cal_pin && off_r > 5'h10)[*5] |-> !cal_request; endproperty
   a_quiet: assert property (p_quiet) else $error("request without cause");
endmodule

/* File: testbench/scwp_host_model.sv */
`timescale 1ns/1ns
module scwp_host_model
(
   output logic cfg_sclk,
   output logic cfg_select_n,
   output logic cfg_serial_in
);
   initial
   begin
      cfg_sclk = 1'h0;
      cfg_select_n = 1'h1;
      cfg_serial_in = 1'h0;
   end
   // Clock stands still between frames; data moves while the clock is low
   task automatic send(input logic [31:0] w, input int n, input logic keep);
      for (int i = 31; i > 31 - n; i--)
      begin
         cfg_select_n = 1'h0;
         cfg_serial_in = w[i];
         #32 cfg_sclk = 1'h1;
         #32 cfg_sclk = 1'h0;
      end
      if (!keep)
      begin
         #16 cfg_select_n = 1'h1;
         cfg_serial_in = ~cfg_serial_in; // No stale bit on a released line
      end
   endtask
endmodule

/* File: testbench/scwp_serial_config_write_port_test.sv */
`timescale 1ns/1ns
module scwp_serial_config_write_port_test;
   logic                 sys_clk = 1'h0;
   logic                 nrst = 1'h0;
   logic                 ext_mode = 1'h1;
   logic                 power_down = 1'h0;
   logic                 cal_pin = 1'h0;
   logic                 cfg_sclk, cfg_select_n, cfg_serial_in, cal_request, regs_active;
   scwp_pkg::scwp_regs_s regs, exp;
   int                   miscompares = 0;
   int                   n_tests = 0;
   int                   cycles = 0;
   always #20 sys_clk = ~sys_clk;
   scwp_host_model scwp_host_model_inst (.*);
   scwp_serial_config_write_port scwp_serial_config_write_port_inst (.*);
   task automatic chk(input logic [127:0] e, input logic [127:0] g);
      n_tests++;
      if (e !== g)
      begin
         miscompares++;
         $display("mismatch at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   task automatic end_of_test;
      if (miscompares == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         miscompares++;
         end_of_test;
      end
   end
   task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic keep);
      scwp_host_model_inst.send({scwp_pkg::HEADER, a, d}, 32, keep);
      if (!keep)
         repeat (6) @(negedge sys_clk);
   endtask
   task automatic t_all;
      logic [3:0] al [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h9, 4'hA, 4'hB, 4'hE, 4'hF};
      foreach (al[i])
         wr(al[i], i == 0 ? 16'h7FFF : {4{al[i]}}, i != 8);
      exp = {16'h1111, 16'h2222, 16'h3333, 16'h9999, 16'hAAAA, 16'hBBBB, 16'hEEEE, 16'hFFFF};
      chk(exp, regs);
   endtask
   task automatic t_refuse;
      logic [3:0] rl [7] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hC, 4'hD};
      foreach (rl[i])
         wr(rl[i], 16'h0000, 1'h0);
      scwp_host_model_inst.send({12'h800, 4'h1, 16'h0000}, 32, 1'h0);
      wr(4'h1, 16'h0000, 1'h1);
      exp.cfg = 16'h0000;
      scwp_host_model_inst.send({scwp_pkg::HEADER, 4'h1, 16'h5A5A}, 31, 1'h0);
      repeat (6) @(negedge sys_clk);
      chk(exp, regs);
   endtask
   task automatic t_mode;
      ext_mode = 1'h0;
      repeat (20) @(negedge sys_clk);
      wr(4'h1, 16'h1234, 1'h0);
      chk(exp, regs);
      chk(1'h0, regs_active);
      ext_mode = 1'h1;
      repeat (6) @(negedge sys_clk);
   endtask
   task automatic t_pd;
      power_down = 1'h1;
      wr(4'h1, 16'hC35A, 1'h0);
      exp.cfg = 16'hC35A;
      chk(1'h0, regs_active);
      power_down = 1'h0;
      repeat (6) @(negedge sys_clk);
      chk(1'h1, regs_active);
      chk(exp, regs);
   endtask
   task automatic t_cal;
      logic seen;
      seen = 1'h0;
      scwp_host_model_inst.send({scwp_pkg::HEADER, 4'h0, 16'hFFFF}, 32, 1'h0);
      repeat (10) @(negedge sys_clk) seen = seen | cal_request;
      chk(1'h1, seen);
      chk(exp, regs);
      cal_pin = 1'h1;
      repeat (5) @(negedge sys_clk);
      chk(1'h1, cal_request);
      cal_pin = 1'h0;
      repeat (5) @(negedge sys_clk);
   endtask
   initial
   begin
      repeat (5) @(negedge sys_clk);
      nrst = 1'h1;
      repeat (4) @(negedge sys_clk);
      chk({8{scwp_pkg::RST_OFS}} | {scwp_pkg::RST_CFG, scwp_pkg::RST_OFS, scwp_pkg::RST_FS,
         scwp_pkg::RST_XCFG, scwp_pkg::RST_OFS, scwp_pkg::RST_FS, scwp_pkg::RST_PHF,
         scwp_pkg::RST_PHC}, regs);
      t_all;
      t_refuse;
      t_mode;
      t_pd;
      t_cal;
      end_of_test;
   end
endmodule
bind scwp_serial_config_write_port scwp_checker scwp_checker_inst (.*);
